// File: hdl/memory_map_boot_remap_ctrl.sv
/*
  Memory controller: address decode into SRAM, external bus and
  peripheral regions, boot and float strap capture, remap of address
  zero, abort on undefined external addresses, per-bank settings.
  Assumes all inputs synchronous to clk; rst_n is asynchronous.
*/
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Watchdog reset keeps straps, else like pin
// - Pin reset governs over simultaneous watchdog
// - Float strap low last 10 cycles
// - Float mode disables all output drivers
// - Low 4MB SRAM, top 4MB peripherals
// - Little-endian byte order everywhere
// - SRAM 32-bit, single-cycle any size
// - Boot width strap: 1=8-bit, 0=16-bit
// - Boot memory at zero until remap
// - Writing remap trigger bit performs remap
// - Remap persists until any reset
// - Abort on undefined external addresses
// - No abort for SRAM or peripherals
// - Banks from 8x1MB to 4x16MB; code keeps all 8 banks live at 16MB
// - Per-bank wait, float, width settings
// - 16-bit: byte-select or byte-write mode
// - Early read selectable per device
// - Sync release, fetch 80 cycles later
// - Any reset restores defaults, fetch zero
module memory_map_boot_remap_ctrl
  import memmap_pkg::*;
#(
  parameter int SRAM_AW = 16
) (
  input wire logic clk, // Master clock
  input wire logic rst_n, // Power-on reset, active low
  input wire logic ext_reset_n, // External reset pin, active low
  input wire logic wdog_reset, // Watchdog internal reset pulse
  input wire logic boot_width_strap, // Boot width strap level
  input wire logic float_outputs_strap, // Float strap, low selects float mode
  input wire memmap_pkg::cpu_req_s cpu_req, // Processor request
  output logic [31:0] cpu_rdata, // Read data
  output logic cpu_ready, // Access complete
  output logic cpu_abort, // Abort to processor
  output logic cpu_reset_n, // Core held in reset while low
  input wire logic remap_wr, // Write strobe to remap control reg
  input wire logic [31:0] remap_wdata, // Data for remap control reg
  input wire memmap_pkg::bank_cfg_s [NUM_BANKS-1:0] bank_cfg_in, // Bank settings
  input wire logic [NUM_BANKS-1:0] bank_cfg_wr, // Bank setting write strobes
  input wire logic [NUM_BANKS-1:0] bank_enable, // Chip select defined
  input wire logic [NUM_BANKS*32-1:0] bank_base_flat, // Bank base addresses
  output memmap_pkg::ext_req_s ext_req, // Request to external bus unit
  output logic [NUM_BANKS-1:0] chip_select_n, // Chip selects, active low
  output logic [NUM_BANKS-1:0] chip_select_oe, // Chip select drivers
  input wire logic ext_done, // External access done
  input wire logic [31:0] ext_rdata, // External read data
  output memmap_pkg::cpu_req_s periph_req, // Request to peripherals
  input wire logic [31:0] periph_rdata, // Peripheral read data
  output logic remapped, // Remap in force
  output logic boot_is_8bit, // Boot memory width is 8 bits
  output logic float_mode, // Float mode in force
  output logic pins_oe // Global output enable for pads
);

  // ****************************************************
  // Reset sources
  // ****************************************************
  // Pin reset wins
  wire pin_reset = !ext_reset_n;
  wire wdog_only = wdog_reset && ext_reset_n;
  wire any_reset = pin_reset || wdog_reset;

  logic [1:0] rel_sync_reg;
  logic sys_rst_n;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rel_sync_reg <= 2'h0;
    end else if (any_reset) begin
      rel_sync_reg <= 2'h0;
    end else begin
      rel_sync_reg <= {rel_sync_reg[0], 1'b1};
    end
  end
  assign sys_rst_n = rel_sync_reg[1];

  // ****************************************************
  // Strap capture
  // ****************************************************
  // Shift histories of the last ten samples during pin reset.
  logic [STRAP_WINDOW_CYCLES-1:0] boot_hist_reg;
  logic [STRAP_WINDOW_CYCLES-1:0] float_hist_reg;
  logic pin_reset_d_reg;
  logic boot_is_8bit_reg;
  logic float_mode_reg;
  wire pin_release = pin_reset_d_reg && !pin_reset;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_hist_reg <= '0;
      float_hist_reg <= '1;
      pin_reset_d_reg <= 1'b0;
    end else begin
      pin_reset_d_reg <= pin_reset;
      if (pin_reset) begin
        boot_hist_reg <= {boot_hist_reg[STRAP_WINDOW_CYCLES-2:0], boot_width_strap};
        float_hist_reg <= {float_hist_reg[STRAP_WINDOW_CYCLES-2:0], float_outputs_strap};
      end
    end
  end

  // Float only if low all window
  wire float_sel = (float_hist_reg == '0);
  wire boot_sel = (boot_hist_reg[0] == BOOT_WIDTH_8);

  // Straps latched on pin release only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_is_8bit_reg <= STRAP_RESET_BOOT;
      float_mode_reg <= STRAP_RESET_FLOAT;
    end else if (pin_release && !wdog_only) begin
      boot_is_8bit_reg <= boot_sel;
      float_mode_reg <= float_sel;
    end
  end
  assign boot_is_8bit = boot_is_8bit_reg;
  assign float_mode = float_mode_reg;
  assign pins_oe = !float_mode_reg;

  // ****************************************************
  // First fetch delay
  // ****************************************************
  logic [6:0] fetch_cnt_reg;
  logic [6:0] fetch_cnt_next;
  localparam logic [6:0] FETCH_LAST = 7'(FETCH_DELAY_CYCLES - 1);
  wire fetch_done = (fetch_cnt_reg == FETCH_LAST);
  assign fetch_cnt_next = fetch_done ? fetch_cnt_reg : fetch_cnt_reg + 7'h01;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_cnt_reg <= 7'h00;
    end else if (!sys_rst_n) begin
      fetch_cnt_reg <= 7'h00;
    end else begin
      fetch_cnt_reg <= fetch_cnt_next;
    end
  end
  assign cpu_reset_n = sys_rst_n && fetch_done;

  // ****************************************************
  // Remap
  // ****************************************************
  logic remapped_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      remapped_reg <= 1'b0;
    end else if (!sys_rst_n) begin
      remapped_reg <= 1'b0;
    end else if (remap_wr && remap_wdata[REMAP_TRIGGER_POS]) begin
      remapped_reg <= 1'b1;
    end
  end
  assign remapped = remapped_reg;

  // ****************************************************
  // Bank settings
  // ****************************************************
  bank_cfg_s [NUM_BANKS-1:0] bank_cfg_reg;
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        bank_cfg_reg[b] <= '0;
      end else if (!sys_rst_n) begin
        bank_cfg_reg[b] <= '0;
      end else if (bank_cfg_wr[b]) begin
        bank_cfg_reg[b] <= bank_cfg_in[b];
      end
    end
  end

  // ****************************************************
  // Address decode
  // ****************************************************
  // Three regions
  wire [31:0] addr = cpu_req.addr;
  wire in_sram_space = (addr < EXT_BASE);
  wire in_periph = (addr >= PERIPH_BASE);
  wire in_ext_space = !in_sram_space && !in_periph;
  // Boot memory at zero before remap
  wire boot_window = in_sram_space && !remapped_reg;
  wire in_sram = in_sram_space && remapped_reg && (addr < SRAM_BYTES);

  // Bank size 0..3 is 1,4,8,16 MB; all banks stay live at 16 MB.
  logic [NUM_BANKS-1:0] bank_hit;
  always_comb begin
    logic [31:0] base;
    logic [31:0] span;
    base = 32'h0000_0000;
    span = 32'h0000_0000;
    bank_hit = '0;
    for (int b = 0; b < NUM_BANKS; b++) begin
      base = bank_base_flat[32*b+:32];
      case (bank_cfg_reg[b].bank_size)
        2'h0: span = 32'h0010_0000;
        2'h1: span = 32'h0040_0000;
        2'h2: span = 32'h0080_0000;
        default: span = 32'h0100_0000;
      endcase
      bank_hit[b] = bank_enable[b] && (addr >= base) && (addr - base < span);
    end
  end

  // Chip selects 1-7 only after remap
  wire [NUM_BANKS-1:0] bank_live = remapped_reg ? bank_enable : {{(NUM_BANKS-1){1'b0}}, 1'b1};
  wire [NUM_BANKS-1:0] ext_hit = bank_hit & bank_live;
  logic [2:0] hit_idx;
  always_comb begin
    hit_idx = 3'h0;
    for (int b = NUM_BANKS - 1; b >= 0; b--) begin
      if (ext_hit[b]) begin
        hit_idx = 3'(b);
      end
    end
  end
  wire ext_defined = boot_window || (|ext_hit);
  wire [2:0] bank_sel = boot_window ? 3'h0 : hit_idx;

  logic [3:0] byte_en;
  always_comb begin
    case (cpu_req.size)
      SIZE_BYTE: byte_en = 4'h1 << addr[1:0];
      SIZE_HALF: byte_en = addr[1] ? 4'hc : 4'h3;
      default: byte_en = 4'hf;
    endcase
  end

  // ****************************************************
  // SRAM
  // ****************************************************
  // Single-cycle SRAM
  logic [31:0] sram_rdata;
  sram_lane_store #(.WORDS(SRAM_WORDS), .AW(SRAM_AW)) u_sram (
    .clk(clk),
    .en(cpu_req.valid && in_sram),
    .we(cpu_req.write),
    .word_addr(addr[SRAM_AW+1:2]),
    .byte_en(byte_en),
    .wdata(cpu_req.wdata),
    .rdata(sram_rdata)
  );

  // ****************************************************
  // Request routing and answers
  // ****************************************************
  wire go = cpu_req.valid && cpu_reset_n;
  wire ext_go = go && (in_ext_space || boot_window);
  // Boot memory width follows the strap until remap, else the bank setting.
  wire bank0_w16 = boot_is_8bit_reg ? 1'b0 : 1'b1;
  wire sel_w16 = (bank_sel == 3'h0 && !remapped_reg) ? bank0_w16 : bank_cfg_reg[bank_sel].width16;

  logic ext_busy_reg;
  ext_req_s ext_req_reg;
  cpu_req_s periph_req_reg;
  logic [31:0] rdata_reg;
  logic ready_reg;
  logic abort_reg;
  logic sram_rd_reg;

  // Byte mode passes to the bus unit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_req_reg <= '0;
      ext_busy_reg <= 1'b0;
    end else if (!sys_rst_n) begin
      ext_req_reg <= '0;
      ext_busy_reg <= 1'b0;
    end else if (ext_busy_reg) begin
      ext_req_reg.valid <= 1'b0;
      ext_busy_reg <= !ext_done;
    end else if (ext_go && ext_defined) begin
      ext_req_reg.valid <= 1'b1;
      ext_req_reg.write <= cpu_req.write;
      ext_req_reg.bank <= bank_sel;
      ext_req_reg.addr <= addr;
      ext_req_reg.wdata <= cpu_req.wdata;
      ext_req_reg.byte_en <= byte_en;
      ext_req_reg.width16 <= sel_w16;
      ext_req_reg.byte_write_mode <= bank_cfg_reg[bank_sel].byte_write_mode;
      ext_req_reg.early_read <= bank_cfg_reg[bank_sel].early_read;
      ext_req_reg.wait_states <= bank_cfg_reg[bank_sel].wait_states;
      ext_req_reg.float_cycles <= bank_cfg_reg[bank_sel].float_cycles;
      ext_busy_reg <= 1'b1;
    end
  end
  assign ext_req = ext_req_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      periph_req_reg <= '0;
    end else begin
      periph_req_reg <= '0;
      if (go && in_periph) begin
        periph_req_reg <= cpu_req;
        // Peripherals are word-only, so low address bits are masked.
        periph_req_reg.addr <= {addr[31:2], 2'h0};
      end
    end
  end
  assign periph_req = periph_req_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sram_rd_reg <= 1'b0;
      ready_reg <= 1'b0;
      abort_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      sram_rd_reg <= go && in_sram;
      abort_reg <= go && !ext_busy_reg && in_ext_space && !boot_window && !ext_defined;
      ready_reg <= (go && (in_sram || in_periph || (in_sram_space && !in_sram && !boot_window)))
        || (ext_busy_reg && ext_done)
        || (go && !ext_busy_reg && in_ext_space && !ext_defined);
      if (ext_busy_reg && ext_done) begin
        rdata_reg <= ext_rdata;
      end else if (periph_req_reg.valid) begin
        rdata_reg <= periph_rdata;
      end
    end
  end
  assign cpu_rdata = sram_rd_reg ? sram_rdata : rdata_reg;
  assign cpu_ready = ready_reg;
  assign cpu_abort = abort_reg;

  // Chip select drivers off in float mode
  for (genvar c = 0; c < NUM_BANKS; c++) begin : g_cs
    assign chip_select_n[c] = !(ext_busy_reg && ext_req_reg.bank == 3'(c));
    assign chip_select_oe[c] = pins_oe;
  end

endmodule
`default_nettype wire

// File: inc/memmap_pkg.sv
/*
  Package for the memory controller: region bounds, strap and reset timing,
  remap control layout, the per-bank settings and the request carriers.
  Assumes a single 100 MHz clock domain.
*/
package memmap_pkg;

  // ****************************************************
  // Clock and timing
  // ****************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int STRAP_WINDOW_CYCLES = 10;
  localparam int FETCH_DELAY_CYCLES = 80;

  // ****************************************************
  // Address regions
  // ****************************************************
  localparam logic [31:0] EXT_BASE = 32'h0040_0000;
  localparam logic [31:0] PERIPH_BASE = 32'hffc0_0000;
  localparam logic [31:0] VECTOR_TOP = 32'h0000_0020;
  localparam logic [31:0] SRAM_BYTES = 32'h0004_0000;
  localparam int SRAM_WORDS = 65536;

  // ****************************************************
  // Remap control and strap values
  // ****************************************************
  localparam int REMAP_TRIGGER_POS = 0;
  localparam logic BOOT_WIDTH_8 = 1'b1;
  localparam logic BOOT_WIDTH_16 = 1'b0;
  localparam logic STRAP_RESET_BOOT = 1'b0;
  localparam logic STRAP_RESET_FLOAT = 1'b0;

  // ****************************************************
  // Per-bank settings
  // ****************************************************
  localparam int NUM_BANKS = 8;
  localparam int WAIT_W = 3;
  localparam int FLOAT_W = 3;

  typedef enum logic [1:0] {
    SIZE_BYTE = 2'h0,
    SIZE_HALF = 2'h1,
    SIZE_WORD = 2'h2
  } access_size_e;

  typedef enum logic [2:0] {
    REGION_SRAM = 3'h1,
    REGION_EXT = 3'h2,
    REGION_PERIPH = 3'h4
  } region_e;

  typedef struct packed {
    logic valid;
    logic write;
    logic fetch;
    access_size_e size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } cpu_req_s;

  typedef struct packed {
    logic width16;
    logic byte_write_mode;
    logic early_read;
    logic [WAIT_W-1:0] wait_states;
    logic [FLOAT_W-1:0] float_cycles;
    logic [1:0] bank_size;
  } bank_cfg_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic [2:0] bank;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] byte_en;
    logic width16;
    logic byte_write_mode;
    logic early_read;
    logic [WAIT_W-1:0] wait_states;
    logic [FLOAT_W-1:0] float_cycles;
  } ext_req_s;

endpackage

// File: hdl/sram_lane_store.sv
/*
  Internal SRAM: 32 bits wide, byte lanes written independently,
  one-cycle read and write. Assumes requests synchronous to clk.
*/
`timescale 1ns/10ps
`default_nettype none
module sram_lane_store #(
  parameter int WORDS = 65536,
  parameter int AW = 16
) (
  input wire logic clk, // Master clock
  input wire logic en, // Access strobe
  input wire logic we, // Write when high
  input wire logic [AW-1:0] word_addr, // Word index
  input wire logic [3:0] byte_en, // Lane enables
  input wire logic [31:0] wdata, // Write data
  output logic [31:0] rdata // Read data, next cycle
);
  logic [31:0] mem [0:WORDS-1];

  always_ff @(posedge clk) begin
    if (en && !we) begin
      rdata <= mem[word_addr];
    end
  end

  // One process writes every lane, so the array has a single driver.
  always_ff @(posedge clk) begin
    if (en && we) begin
      for (int i = 0; i < 4; i++) begin
        if (byte_en[i]) begin
          mem[word_addr][8*i+:8] <= wdata[8*i+:8];
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: test/memmap_props.sv
/*
  Checker for the memory controller, bound to its top module.
  Assumes one clock domain and rst_n as the only disable.
*/
`timescale 1ns/10ps
`default_nettype none
module memmap_props
  import memmap_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic ext_reset_n, // Pin reset
  input wire logic wdog_reset, // Watchdog reset
  input wire memmap_pkg::cpu_req_s cpu_req, // Request
  input wire logic cpu_ready, // Done
  input wire logic cpu_abort, // Abort
  input wire logic cpu_reset_n, // Core reset
  input wire logic remap_wr, // Remap write
  input wire logic [31:0] remap_wdata, // Remap data
  input wire memmap_pkg::ext_req_s ext_req, // External request
  input wire logic [NUM_BANKS-1:0] chip_select_oe, // Select drivers
  input wire logic remapped, // Remap state
  input wire logic boot_is_8bit, // Boot width
  input wire logic float_mode, // Float mode
  input wire logic pins_oe // Pad enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] rel_cnt;
  logic in_rst;
  logic in_ext;
  assign in_rst = !ext_reset_n || wdog_reset;
  assign in_ext = cpu_req.addr >= EXT_BASE && cpu_req.addr < PERIPH_BASE;
  // Cycles since the last reset request went away.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      rel_cnt <= 8'h00;
    else if (in_rst)
      rel_cnt <= 8'h00;
    else if (rel_cnt != 8'hff)
      rel_cnt <= rel_cnt + 8'h01;
  end
  AST_FETCH_DELAY: assert property ($rose(cpu_reset_n) |-> rel_cnt >= 8'h4f && rel_cnt <= 8'h53)
    else $error("core left reset at the wrong time");
  AST_FLOAT_OFF: assert property (float_mode |-> !pins_oe && chip_select_oe == '0)
    else $error("a driver is on in float mode");
  AST_REMAP_SET: assert property (remap_wr && remap_wdata[REMAP_TRIGGER_POS] && !in_rst
    && cpu_reset_n |=> ##[0:1] remapped) else $error("remap write had no effect");
  AST_REMAP_KEEP: assert property ($fell(remapped) |-> !cpu_reset_n || $past(in_rst))
    else $error("remap undone without reset");
  AST_SRAM_ONE: assert property ($rose(cpu_req.valid) && cpu_reset_n && remapped
    && cpu_req.addr < EXT_BASE |=> cpu_ready && !cpu_abort) else $error("sram not one cycle");
  AST_PERIPH_QUIET: assert property ($rose(cpu_req.valid) && cpu_reset_n
    && cpu_req.addr >= PERIPH_BASE |=> cpu_ready && !cpu_abort) else $error("peripheral abort");
  AST_EXT_ROUTE: assert property ($rose(cpu_req.valid) && cpu_reset_n && in_ext
    |=> ext_req.valid != cpu_abort) else $error("external access misrouted");
  AST_ABORT_CAUSE: assert property (cpu_abort |-> cpu_ready && $past(in_ext))
    else $error("abort outside the external region");
  AST_STRAP_KEEP: assert property (wdog_reset && ext_reset_n && $past(ext_reset_n, 3)
    |=> $stable(boot_is_8bit) && $stable(float_mode)) else $error("watchdog moved a strap");
endmodule
bind memory_map_boot_remap_ctrl memmap_props memmap_props_i (.clk, .rst_n, .ext_reset_n,
  .wdog_reset, .cpu_req, .cpu_ready, .cpu_abort, .cpu_reset_n, .remap_wr, .remap_wdata,
  .ext_req, .chip_select_oe, .remapped, .boot_is_8bit, .float_mode, .pins_oe);
`default_nettype wire

// File: test/ext_dev_model.sv
/*
  External bus device model: answers each request after the bank's
  wait states, plus a stall when slow is high. Assumes one-cycle requests.
*/
`timescale 1ns/10ps
`default_nettype none
module ext_dev_model
  import memmap_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic slow, // Stalls every answer
  input wire memmap_pkg::ext_req_s ext_req, // Request
  output logic ext_done, // Answer pulse
  output logic [31:0] ext_rdata // Data, meaningful only with ext_done
);
  logic [31:0] mem [16];
  ext_req_s req;
  int cnt;
  // Idle data changes every cycle so a stale value cannot pass.
  always @(posedge clk or negedge rst_n) begin
    ext_done <= 1'b0;
    ext_rdata <= ~ext_rdata;
    if (!rst_n) begin
      cnt <= 0;
      ext_rdata <= 32'h0000_0000;
    end else if (ext_req.valid) begin
      req <= ext_req;
      cnt <= int'(ext_req.wait_states) + (slow ? 4 : 1);
    end else if (cnt == 1) begin
      cnt <= 0;
      ext_done <= 1'b1;
      ext_rdata <= mem[req.addr[5:2]];
      for (int i = 0; i < 4; i++)
        if (req.write && req.byte_en[i])
          mem[req.addr[5:2]][8*i +: 8] <= req.wdata[8*i +: 8];
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire

// File: test/memory_map_boot_remap_ctrl_test.sv
/*
  Self-checking bench for the memory controller with an external device model.
  Assumes inputs change at the falling edge of a 100 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
module memory_map_boot_remap_ctrl_test;
  import memmap_pkg::*;
  logic clk = 1'b0;
  logic rst_n, ext_reset_n, wdog_reset, boot_width_strap, float_outputs_strap;
  logic cpu_ready, cpu_abort, cpu_reset_n, remap_wr, ext_done, ab, slow;
  logic remapped, boot_is_8bit, float_mode, pins_oe;
  logic [31:0] cpu_rdata, remap_wdata, ext_rdata, periph_rdata, rd;
  cpu_req_s cpu_req, periph_req;
  bank_cfg_s [NUM_BANKS-1:0] bank_cfg_in;
  logic [NUM_BANKS-1:0] bank_cfg_wr, bank_enable, chip_select_n, chip_select_oe, cs_seen;
  logic [NUM_BANKS*32-1:0] bank_base_flat;
  ext_req_s ext_req, last_ext;
  int n_ext = 0;
  int failures = 0;
  int checked = 0;
  always #(CLK_PERIOD_NS / 2) clk = ~clk;
  memory_map_boot_remap_ctrl #(.SRAM_AW(16)) memory_map_boot_remap_ctrl_i (.clk, .rst_n,
    .ext_reset_n, .wdog_reset, .boot_width_strap, .float_outputs_strap, .cpu_req,
    .cpu_rdata, .cpu_ready, .cpu_abort, .cpu_reset_n, .remap_wr, .remap_wdata,
    .bank_cfg_in, .bank_cfg_wr, .bank_enable, .bank_base_flat, .ext_req, .chip_select_n,
    .chip_select_oe, .ext_done, .ext_rdata, .periph_req, .periph_rdata, .remapped,
    .boot_is_8bit, .float_mode, .pins_oe);
  ext_dev_model ext_dev_model_i (.clk, .rst_n, .slow, .ext_req, .ext_done, .ext_rdata);
  always @(posedge clk) begin
    if (ext_req.valid) begin
      last_ext <= ext_req;
      cs_seen <= chip_select_n;
      n_ext <= n_ext + 1;
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (e !== s) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_sim();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic acc(input logic w, input logic f, input access_size_e sz,
                     input logic [31:0] a, input logic [31:0] d);
    int n;
    @(negedge clk);
    cpu_req = '{1'b1, w, f, sz, a, d};
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (cpu_ready !== 1'b1 && n < 60);
    rd = cpu_rdata;
    ab = cpu_abort;
    cpu_req.valid = 1'b0;
    chk("ready", 32'h1, cpu_ready);
  endtask
  // Straps are held 12 cycles before release and 3 after, then boot inverted and float driven high.
  task automatic do_reset(input logic bw, input logic fl, input logic pin, input logic wd);
    int n;
    @(negedge clk);
    boot_width_strap = bw;
    float_outputs_strap = fl;
    ext_reset_n = !pin;
    wdog_reset = wd;
    repeat (12) @(negedge clk);
    ext_reset_n = 1'b1;
    wdog_reset = 1'b0;
    repeat (3) @(negedge clk);
    boot_width_strap = !bw;
    float_outputs_strap = 1'b1;
    n = 0;
    while (cpu_reset_n !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk("cpu_reset_n", 32'h1, cpu_reset_n);
  endtask
  task automatic remap_write(input logic [31:0] d);
    @(negedge clk);
    remap_wr = 1'b1;
    remap_wdata = d;
    @(negedge clk);
    remap_wr = 1'b0;
    @(negedge clk);
  endtask
  task automatic t_straps();
    do_reset(1'b1, 1'b1, 1'b1, 1'b0);
    chk("boot_8", 32'h1, boot_is_8bit);
    chk("float", 32'h0, float_mode);
    chk("pins_oe", 32'h1, pins_oe);
    do_reset(1'b0, 1'b1, 1'b1, 1'b0);
    chk("boot_16", 32'h0, boot_is_8bit);
    chk("remap_rst", 32'h0, remapped);
  endtask
  task automatic t_boot();
    acc(1'b0, 1'b1, SIZE_WORD, 32'h0000_0010, 32'h0);
    chk("boot_bank", 32'h0, last_ext.bank);
    chk("boot_w16", 32'h1, last_ext.width16);
    chk("boot_cs", 32'h0, cs_seen[0]);
    remap_write(32'h0000_0000);
    chk("remap_zero", 32'h0, remapped);
    remap_write(32'h0000_0001);
    chk("remap_set", 32'h1, remapped);
    remap_write(32'h0000_0000);
    chk("remap_keep", 32'h1, remapped);
  endtask
  task automatic t_sram();
    int n0;
    n0 = n_ext;
    acc(1'b1, 1'b0, SIZE_WORD, 32'h0000_0000, 32'h4433_2211);
    acc(1'b1, 1'b0, SIZE_BYTE, 32'h0000_0001, 32'haaaa_aaaa);
    acc(1'b1, 1'b0, SIZE_HALF, 32'h0000_0002, 32'hbeef_beef);
    acc(1'b0, 1'b1, SIZE_WORD, 32'h0000_0000, 32'h0);
    chk("sram_lanes", 32'hbeef_aa11, rd);
    chk("sram_local", n0, n_ext);
  endtask
  task automatic t_ext();
    int n0;
    @(negedge clk);
    bank_cfg_in[1] = '{1'b1, 1'b1, 1'b1, 3'h2, 3'h1, 2'h0};
    bank_cfg_wr = 8'h02;
    slow = 1'b1;
    @(negedge clk);
    bank_cfg_wr = 8'h00;
    acc(1'b1, 1'b0, SIZE_WORD, 32'h0100_0004, 32'hcafe_0123);
    chk("ext_bank", 32'h1, last_ext.bank);
    chk("ext_lanes", 32'hf, last_ext.byte_en);
    chk("ext_wait", 32'h2, last_ext.wait_states);
    chk("ext_float", 32'h1, last_ext.float_cycles);
    chk("ext_modes", 32'h7, {last_ext.width16, last_ext.byte_write_mode, last_ext.early_read});
    chk("ext_cs", 32'h0, cs_seen[1]);
    acc(1'b0, 1'b0, SIZE_WORD, 32'h0100_0004, 32'h0);
    chk("ext_read", 32'hcafe_0123, rd);
    n0 = n_ext;
    acc(1'b0, 1'b0, SIZE_WORD, 32'h0200_0000, 32'h0);
    chk("ext_abort", 32'h1, ab);
    chk("ext_none", n0, n_ext);
    acc(1'b0, 1'b0, SIZE_BYTE, 32'hffff_f001, 32'h0);
    chk("periph_abort", 32'h0, ab);
    chk("periph_addr", 32'hffff_f000, periph_req.addr);
    // Peripheral data lands in the read register one cycle after ready.
    @(negedge clk);
    chk("periph_data", periph_rdata, cpu_rdata);
  endtask
  task automatic t_resets();
    do_reset(1'b1, 1'b0, 1'b0, 1'b1);
    chk("wd_boot", 32'h0, boot_is_8bit);
    chk("wd_float", 32'h0, float_mode);
    chk("wd_remap", 32'h0, remapped);
    do_reset(1'b1, 1'b0, 1'b1, 1'b1);
    chk("both_boot", 32'h1, boot_is_8bit);
    chk("both_float", 32'h1, float_mode);
    chk("float_oe", 32'h0, {pins_oe, chip_select_oe});
  endtask
  initial begin
    rst_n = 1'b0;
    ext_reset_n = 1'b0;
    wdog_reset = 1'b0;
    boot_width_strap = 1'b0;
    float_outputs_strap = 1'b1;
    cpu_req = '0;
    remap_wr = 1'b0;
    remap_wdata = 32'h0;
    bank_cfg_in = '0;
    bank_cfg_wr = 8'h00;
    bank_enable = 8'h03;
    bank_base_flat = '0;
    bank_base_flat[63:0] = 64'h0100_0000_0040_0000;
    periph_rdata = 32'h5a5a_0f0f;
    slow = 1'b0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    t_straps();
    t_boot();
    t_sram();
    t_ext();
    t_resets();
    end_sim();
  end
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    $display("CHECK FAILED run_time expected done seen timeout");
    end_sim();
  end
endmodule
`default_nettype wire
